/* File: verilog/awt_pkg.sv */
/*
 * Constants, register layout and timing for the autonomous watchdog timer.
 * Assumes a 250 MHz system clock and an Avalon-MM slave bus of 32 bits.
 */
`default_nettype none

package awt_pkg;

    // ==========================================================
    // Register map (printed offsets are indices; byte = 4 * index)
    // ==========================================================
    localparam logic [3:0] AWT_IDX_CONTROL = 4'ha;
    localparam logic [3:0] AWT_IDX_IRQ_STATUS = 4'h0;
    localparam logic [3:0] AWT_IDX_IRQ_ENABLE = 4'h1;
    localparam logic [3:0] AWT_IDX_IRQ_CLEAR = 4'h2;

    // ==========================================================
    // Control field positions
    // ==========================================================
    localparam int AWT_BIT_RATE = 0;
    localparam int AWT_BIT_WAKE_IE = 3;
    localparam int AWT_BIT_RESET_EN = 4;
    localparam int AWT_BIT_RESTART = 5;
    localparam logic [7:0] AWT_CONTROL_RESET = 8'h00;

    // Event bits of the status register
    localparam int AWT_EV_TIMEOUT = 0;
    localparam int AWT_EV_WAKE = 1;
    localparam int AWT_NUM_EVENTS = 2;

    // ==========================================================
    // Timing
    // ==========================================================
    localparam longint AWT_CLK_HZ = 250000000;
    localparam longint AWT_FAST_MS = 10;
    localparam longint AWT_SLOW_MS = 20;
    localparam longint AWT_FAST_CYCLES = AWT_FAST_MS * AWT_CLK_HZ / 1000;
    localparam longint AWT_SLOW_CYCLES = AWT_SLOW_MS * AWT_CLK_HZ / 1000;
    localparam int AWT_CNT_W = 32;
    localparam logic [3:0] AWT_RESET_PULSE = 4'h8;

    // Bus state
    typedef enum logic [1:0] {
        AWT_BUS_IDLE = 2'b00,
        AWT_BUS_ACK = 2'b01
    } awt_bus_t;

endpackage : awt_pkg

`default_nettype wire

/* File: verilog/awt_tick_if.sv */
/*
 * Carrier between the control top and the period counter.
 * Assumes both ends share clk_sys.
 */
`default_nettype none

interface awt_tick_if #(parameter int CNT_W = 32);
    logic run_cnt;
    logic clear_cnt;
    logic [CNT_W-1:0] limit;
    logic expired;
    modport ctrl (output run_cnt, output clear_cnt, output limit,
                  input expired);
    modport cnt (input run_cnt, input clear_cnt, input limit,
                 output expired);
endinterface : awt_tick_if

`default_nettype wire

/* File: verilog/awt_period_counter.sv */
/*
 * Period counter: counts while enabled, pulses expired at the limit.
 * Assumes the control top keeps limit stable within a period.
 */
`default_nettype none

module awt_period_counter #(
    parameter int CNT_W = 32
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // Control
    awt_tick_if.cnt tick
);
    import awt_pkg::*;

    logic [CNT_W-1:0] count;
    logic [CNT_W-1:0] next_count;
    logic expired_q;
    logic next_expired;

    always_comb begin
        next_count = count;
        next_expired = 1'b0;
        if (tick.clear_cnt || !tick.run_cnt) begin
            // Halt keeps position so counting resumes later
            if (tick.clear_cnt) begin
                next_count = '0;
            end
        end else if (count >= tick.limit - CNT_W'(1)) begin
            next_count = '0;
            next_expired = 1'b1;
        end else begin
            next_count = count + CNT_W'(1);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            count <= '0;
            expired_q <= 1'b0;
        end else begin
            count <= next_count;
            expired_q <= next_expired;
        end
    end

    assign tick.expired = expired_q;
endmodule : awt_period_counter

`default_nettype wire

/* File: verilog/awt_watchdog.sv */
/*
 * Autonomous watchdog timer top with Avalon-MM register slave.
 * Assumes stop_mode comes synchronous to clk_sys from the power manager,
 * and that the CPU pulls resetn low when sys_reset_req is seen.
 */
`default_nettype none

module awt_watchdog #(
    parameter longint FAST_CYCLES = awt_pkg::AWT_FAST_CYCLES,
    parameter longint SLOW_CYCLES = awt_pkg::AWT_SLOW_CYCLES
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // Avalon-MM slave
    input wire logic [5:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // System mode
    input wire logic stop_mode,
    // Outputs to the CPU
    output logic sys_reset_req,
    output logic wake_irq,
    output logic irq
);
    import awt_pkg::*;

    localparam int CW = AWT_CNT_W;

    // ==========================================================
    // State
    // ==========================================================
    awt_bus_t bus_st, next_bus_st;
    logic [31:0] readdata, next_readdata;
    logic reset_en, next_reset_en;
    logic reset_en_locked, next_reset_en_locked;
    logic wake_ie, next_wake_ie;
    logic rate_fast, next_rate_fast;
    logic [AWT_NUM_EVENTS-1:0] irq_status, next_irq_status;
    logic [AWT_NUM_EVENTS-1:0] irq_enable, next_irq_enable;
    logic irq_q, next_irq_q;
    logic wake_irq_q, next_wake_irq_q;
    logic [3:0] rst_cnt, next_rst_cnt;
    logic restart_pulse, next_restart_pulse;
    logic [CW-1:0] limit_q, next_limit_q;
    logic stop_q, next_stop_q;
    logic waitreq_q, next_waitreq_q;
    logic next_sys_reset_req;

    logic [3:0] idx;
    logic req;
    logic wr_low;
    logic timeout_ev;
    logic wake_ev;

    awt_tick_if #(.CNT_W(CW)) tick ();

    awt_period_counter #(.CNT_W(CW)) u_counter (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .tick(tick)
    );

    function automatic logic [CW-1:0] period_of(input logic fast);
        period_of = fast ? CW'(FAST_CYCLES) : CW'(SLOW_CYCLES);
    endfunction

    assign idx = avs_address[3:0];
    assign req = (avs_read || avs_write) && bus_st == AWT_BUS_IDLE;
    // Writes land at the edge where the master sees waitrequest low
    assign wr_low = avs_write && bus_st == AWT_BUS_ACK && avs_byteenable[0];

    // Timer runs only while an enable is set
    // Run mode needs reset enable; stop mode needs the wake enable
    assign tick.run_cnt = stop_mode ? wake_ie : reset_en;
    // A mode change or restart begins a fresh period
    assign tick.clear_cnt = restart_pulse || (stop_q != stop_mode);
    assign tick.limit = limit_q;

    assign timeout_ev = tick.expired && !stop_q && reset_en;
    assign wake_ev = tick.expired && stop_q && wake_ie;

    // ==========================================================
    // Next-state logic
    // ==========================================================
    always_comb begin
        next_bus_st = AWT_BUS_IDLE;
        next_readdata = readdata;
        next_reset_en = reset_en;
        next_reset_en_locked = reset_en_locked;
        next_wake_ie = wake_ie;
        next_rate_fast = rate_fast;
        next_irq_enable = irq_enable;
        next_irq_status = irq_status;
        next_restart_pulse = 1'b0;
        next_stop_q = stop_mode;
        next_limit_q = period_of(rate_fast);
        next_rst_cnt = rst_cnt;
        if (req) begin
            next_bus_st = AWT_BUS_ACK;
            next_readdata = '0;
            if (avs_read) begin
                case (idx)
                    AWT_IDX_CONTROL: begin
                        // Restart and bit two read back as zero
                        next_readdata[AWT_BIT_RESET_EN] = reset_en;
                        next_readdata[AWT_BIT_WAKE_IE] = wake_ie;
                        next_readdata[AWT_BIT_RATE] = rate_fast;
                    end
                    AWT_IDX_IRQ_STATUS: begin
                        next_readdata[AWT_NUM_EVENTS-1:0] = irq_status;
                    end
                    AWT_IDX_IRQ_ENABLE: begin
                        next_readdata[AWT_NUM_EVENTS-1:0] = irq_enable;
                    end
                    default: begin
                        next_readdata = '0;
                    end
                endcase
            end
        end
        if (wr_low) begin
            case (idx)
                AWT_IDX_CONTROL: begin
                    if (avs_writedata[AWT_BIT_RESTART]) begin
                        next_restart_pulse = 1'b1;
                    end
                    // A write of reset enable as one fixes it until reset
                    if (!reset_en_locked) begin
                        next_reset_en = avs_writedata[AWT_BIT_RESET_EN];
                        next_reset_en_locked =
                            avs_writedata[AWT_BIT_RESET_EN];
                    end
                    next_wake_ie = avs_writedata[AWT_BIT_WAKE_IE];
                    next_rate_fast = avs_writedata[AWT_BIT_RATE];
                end
                AWT_IDX_IRQ_ENABLE: begin
                    next_irq_enable =
                        avs_writedata[AWT_NUM_EVENTS-1:0];
                end
                AWT_IDX_IRQ_CLEAR: begin
                    next_irq_status =
                        irq_status & ~avs_writedata[AWT_NUM_EVENTS-1:0];
                end
                default: begin
                    next_irq_status = irq_status;
                end
            endcase
        end
        // Set after clear so a same-cycle event is kept
        if (timeout_ev) begin
            next_irq_status[AWT_EV_TIMEOUT] = 1'b1;
        end
        if (wake_ev) begin
            next_irq_status[AWT_EV_WAKE] = 1'b1;
        end
        // Stretch the reset request so the CPU surely sees it
        if (timeout_ev) begin
            next_rst_cnt = AWT_RESET_PULSE;
        end else if (rst_cnt != 4'h0) begin
            next_rst_cnt = rst_cnt - 4'h1;
        end
        next_irq_q = |(next_irq_status & irq_enable);
        // Wake level held until the CPU leaves stop mode
        next_wake_irq_q = stop_mode && (wake_irq_q || wake_ev);
        next_waitreq_q = (next_bus_st != AWT_BUS_ACK);
        next_sys_reset_req = (next_rst_cnt != 4'h0);
    end

    // ==========================================================
    // Registers
    // ==========================================================
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            bus_st <= AWT_BUS_IDLE;
            readdata <= '0;
            reset_en <= AWT_CONTROL_RESET[AWT_BIT_RESET_EN];
            reset_en_locked <= 1'b0;
            wake_ie <= AWT_CONTROL_RESET[AWT_BIT_WAKE_IE];
            rate_fast <= AWT_CONTROL_RESET[AWT_BIT_RATE];
            irq_status <= '0;
            irq_enable <= '0;
            irq_q <= 1'b0;
            wake_irq_q <= 1'b0;
            rst_cnt <= 4'h0;
            restart_pulse <= 1'b0;
            limit_q <= CW'(SLOW_CYCLES);
            stop_q <= 1'b0;
            sys_reset_req <= 1'b0;
            waitreq_q <= 1'b1;
        end else begin
            bus_st <= next_bus_st;
            readdata <= next_readdata;
            reset_en <= next_reset_en;
            reset_en_locked <= next_reset_en_locked;
            wake_ie <= next_wake_ie;
            rate_fast <= next_rate_fast;
            irq_status <= next_irq_status;
            irq_enable <= next_irq_enable;
            irq_q <= next_irq_q;
            wake_irq_q <= next_wake_irq_q;
            rst_cnt <= next_rst_cnt;
            restart_pulse <= next_restart_pulse;
            limit_q <= next_limit_q;
            stop_q <= next_stop_q;
            sys_reset_req <= next_sys_reset_req;
            waitreq_q <= next_waitreq_q;
        end
    end

    assign avs_readdata = readdata;
    // Waitrequest high unless the answer is ready this cycle
    assign avs_waitrequest = waitreq_q;
    assign irq = irq_q;
    assign wake_irq = wake_irq_q;
endmodule : awt_watchdog

`default_nettype wire

/* File: tb/awt_watchdog_asserts.sv */
/* Port checker for the watchdog top.
   Assumes a bind to awt_watchdog with its period parameters. */
`default_nettype none
module awt_watchdog_asserts #(
    parameter longint FAST_CYCLES = 20,
    parameter longint SLOW_CYCLES = 40
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // Bus
    input wire logic [5:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    // Mode and outputs
    input wire logic stop_mode,
    input wire logic sys_reset_req,
    input wire logic wake_irq,
    input wire logic irq
);
    timeunit 1ns;
    timeprecision 1ps;
    // =======
    // Helpers
    // =======
    // Lower bounds only: the design restarts one cycle after the write
    int run_cnt;
    int stop_cnt;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    always_ff @(posedge clk_sys) begin
        stop_cnt <= (resetn && stop_mode) ? stop_cnt + 1 : 0;
        if (!resetn || stop_mode || (avs_write && !avs_waitrequest &&
            avs_address[3:0] == 4'ha && avs_writedata[5]))
            run_cnt <= 0;
        else
            run_cnt <= run_cnt + 1;
    end
    // ==========
    // Properties
    // ==========
    wait_ack_a: assert property ($rose(avs_read || avs_write) |->
        avs_waitrequest ##1 !avs_waitrequest) else $error("bus answer late");
    ctl_zero_a: assert property (avs_read && !avs_waitrequest &&
        avs_address[3:0] == 4'ha |-> avs_readdata[7:5] == 3'h0 &&
        !avs_readdata[2]) else $error("control zero bits set");
    idle_out_a: assert property ($rose(resetn) |-> avs_waitrequest &&
        !sys_reset_req && !wake_irq && !irq) else $error("outputs after reset");
    rst_len_a: assert property ($rose(sys_reset_req) |->
        sys_reset_req [*8] ##1 !sys_reset_req) else $error("reset pulse length");
    rst_run_a: assert property ($rose(sys_reset_req) |->
        !$past(stop_mode) && run_cnt >= FAST_CYCLES - 1)
        else $error("reset request early or in stop");
    wake_stop_a: assert property (wake_irq |->
        stop_mode || $past(stop_mode)) else $error("wake outside stop");
    wake_drop_a: assert property ($fell(stop_mode) |=> !wake_irq)
        else $error("wake held after stop");
    wake_time_a: assert property ($rose(wake_irq) |->
        stop_cnt >= FAST_CYCLES - 1 && stop_cnt <= SLOW_CYCLES + 4)
        else $error("wake period wrong");
    cover property ($rose(sys_reset_req));
    cover property ($rose(wake_irq));
    cover property ($rose(irq));
endmodule // awt_watchdog_asserts
bind awt_watchdog awt_watchdog_asserts #(.FAST_CYCLES(FAST_CYCLES),
    .SLOW_CYCLES(SLOW_CYCLES)) u_chk (.clk_sys(clk_sys), .resetn(resetn),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .stop_mode(stop_mode),
    .sys_reset_req(sys_reset_req), .wake_irq(wake_irq), .irq(irq));
`default_nettype wire

/* File: tb/awt_cpu_model.sv */
/* CPU side: sleeps on request, wakes on the wake line, resets itself.
   Assumes one clock shared with the watchdog. */
`default_nettype none
module awt_cpu_model #(
    parameter int LAT = 1
) (
    // Clock
    input wire logic clk_sys,
    // From bench and watchdog
    input wire logic sleep_req,
    input wire logic sys_reset_req,
    input wire logic wake_irq,
    // To watchdog
    output logic stop_mode,
    output logic cpu_rstn
);
    timeunit 1ns;
    timeprecision 1ps;
    logic woke;
    logic rst_q;
    int rcnt;
    // Reset follows the end of the pulse so its full length is visible
    always_ff @(posedge clk_sys) begin
        rst_q <= sys_reset_req;
        woke <= sleep_req && (woke || wake_irq);
        stop_mode <= sleep_req && !woke && !wake_irq;
        if (rst_q && !sys_reset_req)
            rcnt <= LAT;
        else if (rcnt != 0)
            rcnt <= rcnt - 1;
        cpu_rstn <= (rcnt == 0);
    end
endmodule // awt_cpu_model
`default_nettype wire

/* File: tb/awt_watchdog_tb.sv */
/* Self-checking bench for the watchdog top.
   Assumes the design package and the checker are compiled first. */
`default_nettype none
module awt_watchdog_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import awt_pkg::*;
    localparam longint FAST = 20;
    localparam longint SLOW = 40;
    logic clk_sys = 1'b0;
    logic rst_b = 1'b0;
    logic sleep_req = 1'b0;
    logic [5:0] avs_address = 6'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest, stop_mode, sys_reset_req, wake_irq, irq;
    logic cpu_rstn, resetn;
    logic [31:0] exq[$];
    logic [31:0] lfsr = 32'h53ab6f76;
    logic [7:0] ctl_t [3] = '{8'h09, 8'h08, 8'h09};
    int fails = 0;
    int cmp_count = 0;
    int n;
    assign resetn = rst_b & cpu_rstn;
    awt_watchdog #(.FAST_CYCLES(FAST), .SLOW_CYCLES(SLOW)) dut (
        .clk_sys(clk_sys), .resetn(resetn), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .stop_mode(stop_mode), .sys_reset_req(sys_reset_req),
        .wake_irq(wake_irq), .irq(irq));
    awt_cpu_model #(.LAT(3)) cpu (.clk_sys(clk_sys), .sleep_req(sleep_req),
        .sys_reset_req(sys_reset_req), .wake_irq(wake_irq),
        .stop_mode(stop_mode), .cpu_rstn(cpu_rstn));
    initial forever #2 clk_sys = ~clk_sys;
    // =====
    // Tasks
    // =====
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED %s exp %h seen %h", what, exp, seen);
        end
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic bus(input logic wr, input logic [3:0] a,
                       input logic [7:0] d, input logic [7:0] e);
        int k = 0;
        avs_address <= {2'h0, a};
        avs_writedata <= {24'h0, d};
        avs_write <= wr;
        avs_read <= !wr;
        if (!wr) exq.push_back({24'h0, e});
        do begin
            @(posedge clk_sys);
            k++;
        end while (avs_waitrequest !== 1'b0 && k < 50);
        if (k >= 50) begin
            fails++;
            final_report();
        end
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clk_sys);
    endtask
    // Waits for the reset request (rst) or the wake line
    task automatic wait_hi(input logic rst, input int lim);
        n = 0;
        while ((rst ? sys_reset_req : wake_irq) !== 1'b1) begin
            @(posedge clk_sys);
            n++;
            if (n >= lim) begin
                fails++;
                final_report();
            end
        end
    endtask
    always @(posedge clk_sys)
        if (avs_read && avs_waitrequest === 1'b0 && exq.size() > 0)
            check("readdata", avs_readdata, exq.pop_front());
    // =========
    // Sequence
    // =========
    initial begin
        longint lim;
        logic [7:0] d;
        repeat (6) @(posedge clk_sys);
        rst_b <= 1'b1;
        @(posedge clk_sys);
        bus(0, AWT_IDX_CONTROL, 8'h0, AWT_CONTROL_RESET);
        bus(0, 4'h5, 8'h0, 8'h00);
        bus(1, AWT_IDX_CONTROL, 8'h21, 8'h0);
        bus(0, AWT_IDX_CONTROL, 8'h0, 8'h01);
        // Wake at both rates, last one with the interrupt masked
        for (int i = 0; i < 3; i++) begin
            lim = ctl_t[i][0] ? FAST : SLOW;
            bus(1, AWT_IDX_IRQ_ENABLE, (i == 2) ? 8'h00 : 8'h03, 8'h0);
            bus(1, AWT_IDX_CONTROL, ctl_t[i], 8'h0);
            sleep_req <= 1'b1;
            wait_hi(0, 200);
            check("wake_time", n >= lim && n <= lim + 6, 1);
            repeat (2) @(posedge clk_sys);
            check("irq_on", irq, i != 2);
            sleep_req <= 1'b0;
            bus(0, AWT_IDX_IRQ_STATUS, 8'h0, 8'h02);
            bus(1, AWT_IDX_IRQ_CLEAR, 8'h02, 8'h0);
            repeat (2) @(posedge clk_sys);
            check("irq_off", irq, 0);
        end
        bus(1, AWT_IDX_CONTROL, 8'h01, 8'h0);
        sleep_req <= 1'b1;
        repeat (3 * SLOW) begin
            @(posedge clk_sys);
            check("wake_masked", wake_irq, 0);
        end
        sleep_req <= 1'b0;
        // Watchdog kept alive by restarts with random wake enable and spare bits
        for (int i = 0; i < 6; i++) begin
            lfsr = lfsr_next(lfsr);
            d = 8'h31 | (lfsr[7:0] & 8'hca); // Bit two kept zero
            bus(1, AWT_IDX_CONTROL, d, 8'h0);
            repeat (lfsr[10:8]) begin
                @(posedge clk_sys);
                check("no_reset", sys_reset_req, 0);
            end
        end
        bus(0, AWT_IDX_CONTROL, 8'h0, d & 8'h19);
        bus(1, AWT_IDX_CONTROL, 8'h00, 8'h0);
        bus(0, AWT_IDX_CONTROL, 8'h0, 8'h10);
        sleep_req <= 1'b1;
        repeat (3 * SLOW) begin
            @(posedge clk_sys);
            check("stop_hold", sys_reset_req | wake_irq, 0);
        end
        sleep_req <= 1'b0;
        wait_hi(1, SLOW + 20);
        check("reset_req", sys_reset_req, 1);
        n = 0;
        while (resetn !== 1'b0 && n < 40) begin
            @(posedge clk_sys);
            n++;
        end
        while (resetn !== 1'b1 && n < 80) begin
            @(posedge clk_sys);
            n++;
        end
        check("cpu_reset", n < 80, 1);
        @(posedge clk_sys);
        bus(0, AWT_IDX_CONTROL, 8'h0, 8'h00);
        final_report();
    end
endmodule // awt_watchdog_tb
`default_nettype wire
